// ### hdl/scsm_clock_select.sv
// Top of the system clock select and monitor block, one design file.
// Assumes oscillators and clock-divider ticks arrive as asynchronous levels
// and are resynchronised here; clock outputs are registered enables.
`include "scsm_defs.svh"
`default_nettype none
module scsm_clock_select (
   input  wire logic                              clk,
   input  wire logic                              reset,
   // ----------------------------------------------------------------
   // Sources and control
   // ----------------------------------------------------------------
   input  wire logic                              internal_rc_osc,
   input  wire logic                              external_fast_osc,
   input  wire logic                              multiplier_output_clock,
   input  wire logic                              ext_select,
   input  wire logic                              monitor_enable,
   input  wire logic                              fail_irq_enable,
   input  wire logic                              mult_irq_enable,
   input  wire logic                              fail_clear,
   input  wire logic                              mult_from_internal,
   input  wire logic [`SCSM_PRESC_W-1:0]          slow_presc,
   input  wire logic [`SCSM_PRESC_W-1:0]          fast_presc,
   input  wire logic                              slow_bus_tick,
   input  wire logic                              fast_bus_tick,
   input  wire logic [`SCSM_N_SLOW_PERIPH-1:0]    slow_periph_en,
   input  wire logic [`SCSM_N_FAST_PERIPH-1:0]    fast_periph_en,
   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   output logic                                   system_clock,
   output logic                                   ext_active,
   output logic                                   fail_flag,
   output logic                                   fail_irq,
   output logic                                   mult_fail_irq,
   output logic                                   mult_limit_64,
   output logic                                   general_timer_clock,
   output logic                                   advanced_timer_clock,
   output logic [`SCSM_N_SLOW_PERIPH-1:0]         slow_periph_clk,
   output logic [`SCSM_N_FAST_PERIPH-1:0]         fast_periph_clk
);

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   // Every source and bus tick is a free-running level from another
   // clock, so each one passes two flip-flops before any logic reads it.
   // The first stage is read only by the second stage; a third register
   // keeps the previous settled value for edge detection.
   // All stages reset low, matching the idle level of the sources, so no
   // false edge is seen right after reset.
   // Order of the bundle, most significant first:
   //    internal source, external source, multiplier output,
   //    slow bus tick, fast bus tick.
   localparam int NS = 5;
   logic [NS-1:0] sync1_q;   // First stage, read only by second stage
   logic [NS-1:0] sync2_q;   // Second stage, safe to use
   logic [NS-1:0] sync_in;   // Raw asynchronous inputs
   logic [NS-1:0] prev_q;    // Previous synchronised value for edge detect

   assign sync_in = {internal_rc_osc, external_fast_osc, multiplier_output_clock,
                     slow_bus_tick, fast_bus_tick};

   // Two flip-flops on each asynchronous input
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sync1_q <= '0;
         sync2_q <= '0;
         prev_q  <= '0;
      end else begin
         sync1_q <= sync_in;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   logic int_lvl, ext_lvl, mult_edge, ext_edge, slow_edge, fast_edge;
   assign int_lvl   = sync2_q[4];
   assign ext_lvl   = sync2_q[3];
   assign ext_edge  = sync2_q[3] ^ prev_q[3];
   assign mult_edge = sync2_q[2] ^ prev_q[2];
   assign slow_edge = sync2_q[1] & ~prev_q[1];
   assign fast_edge = sync2_q[0] & ~prev_q[0];

   // ----------------------------------------------------------------
   // Failure watchdogs
   // ----------------------------------------------------------------
   logic [`SCSM_CNT_W-1:0] ext_cnt_d, ext_cnt_q;    // Cycles since external edge
   logic [`SCSM_CNT_W-1:0] mult_cnt_d, mult_cnt_q;  // Cycles since multiplier edge
   logic ext_fail, mult_fail;
   scsm_pkg::scsm_state_t st_d, st_q;               // Switch state

   // Each watchdog counts cycles with no edge on its source. It saturates
   // at the failure threshold, so the failure stays visible until the
   // source edges again, is deselected or the watch is turned off.
   // The external watch runs only while that source is in use; the
   // multiplier watch runs whenever monitoring is enabled.
   // Count silence on each source; restart on every edge
   always_comb begin
      ext_cnt_d  = ext_cnt_q;
      mult_cnt_d = mult_cnt_q;
      if (ext_edge || !monitor_enable || st_q == scsm_pkg::SCSM_ST_INT) begin
         ext_cnt_d = '0;   // Watch only while external is selected
      end else if (!ext_fail) begin
         ext_cnt_d = ext_cnt_q + `SCSM_CNT_W'(1);
      end
      if (mult_edge || !monitor_enable) begin
         mult_cnt_d = '0;
      end else if (!mult_fail) begin
         mult_cnt_d = mult_cnt_q + `SCSM_CNT_W'(1);
      end
   end
   assign ext_fail  = (ext_cnt_q  >= `SCSM_CNT_W'(`SCSM_FAIL_CYCLES));
   assign mult_fail = (mult_cnt_q >= `SCSM_CNT_W'(`SCSM_FAIL_CYCLES));

   // ----------------------------------------------------------------
   // Source switch: stop old source low, then start new one
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      case (st_q)
         scsm_pkg::SCSM_ST_INT: begin
            // Leave only on a low internal phase, no short pulse
            if (ext_select && !fail_flag && !int_lvl) st_d = scsm_pkg::SCSM_ST_STOP_INT;
         end
         scsm_pkg::SCSM_ST_STOP_INT: begin
            if (!ext_lvl) st_d = scsm_pkg::SCSM_ST_EXT;
         end
         scsm_pkg::SCSM_ST_EXT: begin
            // Automatic fallback, no software needed
            if (ext_fail) st_d = scsm_pkg::SCSM_ST_SEL_INT;
            else if (!ext_select && !ext_lvl) st_d = scsm_pkg::SCSM_ST_STOP_EXT;
         end
         scsm_pkg::SCSM_ST_STOP_EXT,
         scsm_pkg::SCSM_ST_SEL_INT: begin
            if (!int_lvl) st_d = scsm_pkg::SCSM_ST_INT;
         end
         default: st_d = scsm_pkg::SCSM_ST_INT;
      endcase
   end

   // ----------------------------------------------------------------
   // Flags, interrupts and clock outputs
   // ----------------------------------------------------------------
   logic fail_d, irq_d, mirq_d, sys_d, tim_g_d, tim_a_d;
   logic [`SCSM_N_SLOW_PERIPH-1:0] sp_d;
   logic [`SCSM_N_FAST_PERIPH-1:0] fp_d;
   logic mult_fail_q;

   always_comb begin
      // Sticky failure flag: set beats clear
      fail_d = (fail_flag && !fail_clear) || (ext_fail && st_q == scsm_pkg::SCSM_ST_EXT);
      irq_d  = fail_d && fail_irq_enable;
      mirq_d = (mult_fail_q && !fail_clear) || mult_fail;
      // System clock follows the selected source, held low while switching
      case (st_q)
         scsm_pkg::SCSM_ST_INT: sys_d = int_lvl;
         scsm_pkg::SCSM_ST_EXT: sys_d = ext_lvl;
         default:               sys_d = 1'b0;
      endcase
      // Timer clocks: x1 bus when prescaler is 1, else x2 (both edges)
      tim_g_d = (slow_presc == `SCSM_PRESC_DIV1) ? sync2_q[1] : slow_edge;
      tim_a_d = (fast_presc == `SCSM_PRESC_DIV1) ? sync2_q[0] : fast_edge;
      if (slow_presc != `SCSM_PRESC_DIV1) tim_g_d = sync2_q[1] ^ prev_q[1];
      if (fast_presc != `SCSM_PRESC_DIV1) tim_a_d = sync2_q[0] ^ prev_q[0];
      // Peripheral clocks gated per enable
      sp_d = slow_periph_en & {`SCSM_N_SLOW_PERIPH{sync2_q[1]}};
      fp_d = fast_periph_en & {`SCSM_N_FAST_PERIPH{sync2_q[0]}};
   end

   // Every output leaves straight from a flip-flop, so consumers never
   // see decode glitches. The cost is one cycle of latency on each of
   // them, which the failure timeout easily absorbs.
   // A reset in mid-run drops any external selection at once and clears
   // the sticky flags; if ext_select is still high, the switch to the external source starts again.
   // Register all state and outputs; reset returns to internal source
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_q                 <= scsm_pkg::SCSM_ST_INT;
         ext_cnt_q            <= '0;
         mult_cnt_q           <= '0;
         mult_fail_q          <= 1'b0;
         fail_flag            <= 1'b0;
         fail_irq             <= 1'b0;
         mult_fail_irq        <= 1'b0;
         system_clock         <= 1'b0;
         ext_active           <= 1'b0;
         mult_limit_64        <= 1'b0;
         general_timer_clock  <= 1'b0;
         advanced_timer_clock <= 1'b0;
         slow_periph_clk      <= '0;
         fast_periph_clk      <= '0;
      end else begin
         st_q                 <= st_d;
         ext_cnt_q            <= ext_cnt_d;
         mult_cnt_q           <= mult_cnt_d;
         mult_fail_q          <= mirq_d;
         fail_flag            <= fail_d;
         fail_irq             <= irq_d;
         mult_fail_irq        <= mirq_d && mult_irq_enable;
         system_clock         <= sys_d;
         ext_active           <= (st_q == scsm_pkg::SCSM_ST_EXT);
         mult_limit_64        <= mult_from_internal;
         general_timer_clock  <= tim_g_d;
         advanced_timer_clock <= tim_a_d;
         slow_periph_clk      <= sp_d;
         fast_periph_clk      <= fp_d;
      end
   end

endmodule
`default_nettype wire

// ### hdl/scsm_defs.svh
// Constants of the system clock select and monitor block.
// Assumes one clk domain at 125 MHz; included by the top module, the checker and the bench.
//
// How it works
// - Reset always selects internal oscillator, 8 MHz.
// - External source watched while it is selected.
// - Failure forces automatic return to internal oscillator.
// - Failure interrupt raised only when enabled.
// - Multiplier input failure also reported to software.
// - Internal source through multiplier raises the 64 MHz limit flag.
// - General timer clock x1 or x2 slow bus.
// - Advanced timer clock x1 or x2 fast bus.
`ifndef SCSM_DEFS_SVH
`define SCSM_DEFS_SVH

`define SCSM_INT_OSC_MHZ      8
`define SCSM_CLK_MHZ          125
// Time without an external edge that counts as a failure, in ns
`define SCSM_FAIL_TIME_NS     1000
`define SCSM_FAIL_CYCLES      ((`SCSM_FAIL_TIME_NS * `SCSM_CLK_MHZ) / 1000)
`define SCSM_CNT_W            8
`define SCSM_SYNC_STAGES      2
`define SCSM_PRESC_W          3
`define SCSM_PRESC_DIV1       3'h0
`define SCSM_N_SLOW_PERIPH    13
`define SCSM_N_FAST_PERIPH    11

`endif

// ### hdl/scsm_pkg.sv
// Types of the system clock select and monitor block.
// Includes no header, so it needs nothing on the include path.
`default_nettype none
package scsm_pkg;
   // Source switching state machine
   typedef enum logic [2:0] {
      SCSM_ST_INT      = 3'b000,
      SCSM_ST_STOP_INT = 3'b001,
      SCSM_ST_EXT      = 3'b010,
      SCSM_ST_STOP_EXT = 3'b011,
      SCSM_ST_SEL_INT  = 3'b100
   } scsm_state_t;
endpackage
`default_nettype wire

// ### verif/scsm_check_sva.sv
// Assertions on the ports of the clock select block.
// Assumes the defines header on the include path; bound to the top module.
`include "scsm_defs.svh"
`default_nettype none
module scsm_check (
   input wire logic                           clk,
   input wire logic                           reset,
   input wire logic                           monitor_enable,
   input wire logic                           fail_irq_enable,
   input wire logic                           mult_from_internal,
   input wire logic [`SCSM_N_SLOW_PERIPH-1:0] slow_periph_en,
   input wire logic [`SCSM_N_FAST_PERIPH-1:0] fast_periph_en,
   input wire logic                           system_clock,
   input wire logic                           ext_active,
   input wire logic                           fail_flag,
   input wire logic                           fail_irq,
   input wire logic                           mult_limit_64,
   input wire logic [`SCSM_N_SLOW_PERIPH-1:0] slow_periph_clk,
   input wire logic [`SCSM_N_FAST_PERIPH-1:0] fast_periph_clk
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_reset_internal: assert property ($fell(reset) |-> !ext_active && !fail_flag)
      else $error("source not internal after reset");
   a_fail_watched: assert property ($rose(fail_flag) |-> $past(ext_active) && $past(monitor_enable))
      else $error("failure flagged without watch");
   a_fail_fallback: assert property (fail_flag [*3] |-> !ext_active)
      else $error("external source kept after failure");
   a_irq_masked: assert property (!fail_irq_enable && !$past(fail_irq_enable) |-> !fail_irq)
      else $error("failure request while disabled");
   a_limit_flag: assert property (!$past(reset) |-> mult_limit_64 == $past(mult_from_internal))
      else $error("limit flag wrong");
   a_switch_quiet: assert property ($rose(ext_active) |-> !$past(system_clock))
      else $error("system clock not held low at switch");
   a_slow_gated: assert property (!$past(reset) |-> (slow_periph_clk & ~$past(slow_periph_en)) == '0)
      else $error("disabled slow peripheral clocked");
   a_fast_gated: assert property (!$past(reset) |-> (fast_periph_clk & ~$past(fast_periph_en)) == '0)
      else $error("disabled fast peripheral clocked");
endmodule
bind scsm_clock_select scsm_check u_chk (.clk, .reset, .monitor_enable, .fail_irq_enable,
   .mult_from_internal, .slow_periph_en, .fast_periph_en, .system_clock, .ext_active,
   .fail_flag, .fail_irq, .mult_limit_64, .slow_periph_clk, .fast_periph_clk);
`default_nettype wire

// ### verif/scsm_clock_select_test.sv
// Self-checking bench of the clock select block with the oscillator model.
// Assumes design, defines header, model and checker compiled before it.
`include "scsm_defs.svh"
`default_nettype none
module scsm_clock_select_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk, reset, ext_select, monitor_enable, fail_irq_enable, mult_irq_enable;
   logic        fail_clear, mult_from_internal, ext_run, mult_run, g_q, a_q;
   logic        int_osc, ext_osc, mult_clk, slow_tick, fast_tick, system_clock, ext_active;
   logic        fail_flag, fail_irq, mult_fail_irq, mult_limit_64, gen_tclk, adv_tclk;
   logic [2:0]  slow_presc, fast_presc;
   logic [12:0] slow_periph_en, slow_periph_clk;
   logic [10:0] fast_periph_en, fast_periph_clk;
   logic [13:0] exp_q[$];
   logic [13:0] nt;
   int          n_mismatch, num_checks, cg, ca, p;
   int          seed = 32'h430E0CB6;
   scsm_osc_model osc (.ext_run, .mult_run, .int_osc, .ext_osc, .mult_clk, .slow_tick,
      .fast_tick);
   scsm_clock_select uut (.clk, .reset, .internal_rc_osc(int_osc), .external_fast_osc(ext_osc),
      .multiplier_output_clock(mult_clk), .ext_select, .monitor_enable, .fail_irq_enable,
      .mult_irq_enable, .fail_clear, .mult_from_internal, .slow_presc, .fast_presc,
      .slow_bus_tick(slow_tick), .fast_bus_tick(fast_tick), .slow_periph_en, .fast_periph_en,
      .system_clock, .ext_active, .fail_flag, .fail_irq, .mult_fail_irq, .mult_limit_64,
      .general_timer_clock(gen_tclk), .advanced_timer_clock(adv_tclk), .slow_periph_clk,
      .fast_periph_clk);
   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   // Counts timer clock toggles; watcher compares the oldest note with the outputs
   always @(posedge clk) begin
      g_q <= gen_tclk;
      a_q <= adv_tclk;
      if (g_q !== gen_tclk) cg++;
      if (a_q !== adv_tclk) ca++;
      if (exp_q.size() > 0) begin
         nt = exp_q.pop_front();
         check({ca > 60, cg > 30, ext_active, fail_flag, fail_irq, mult_fail_irq,
            mult_limit_64} & nt[13:7], nt[6:0]);
      end
   end
   task automatic check(input logic [6:0] s, input logic [6:0] e);
      num_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // Notes a masked expectation one edge later, so outputs have settled
   task automatic note(input logic [6:0] m, input logic [6:0] e, input string t);
      @(negedge clk);
      exp_q.push_back({m, e});
      @(negedge clk);
      $display("test %s done", t);
   endtask
   task automatic wait_on(ref logic s, input int n);
      for (int k = 0; k < n && s !== 1'b1; k++) @(negedge clk);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Whole run is some 1900 cycles; this limit sits far beyond it
   initial begin
      #200000;
      n_mismatch++;
      results;
   end
   initial begin
      {ext_select, monitor_enable, fail_irq_enable, mult_irq_enable, fail_clear} = '0;
      {mult_from_internal, slow_presc, fast_presc} = '0;
      {ext_run, mult_run} = 2'h3;
      slow_periph_en = $random(seed);
      fast_periph_en = $random(seed);
      reset = 1;
      repeat (3) @(negedge clk);
      reset = 0;
      note(7'h1F, 7'h00, "reset");
      mult_from_internal = 1;
      note(7'h01, 7'h01, "limit");
      for (p = 0; p < 8; p++) begin
         slow_presc = p[2:0];
         fast_presc = p[2:0];
         repeat (8) @(negedge clk);
         {cg, ca} = '0;
         repeat (160) @(negedge clk);
         note(7'h60, (p == 0) ? 7'h00 : 7'h60, "timers");
      end
      {monitor_enable, fail_irq_enable, mult_irq_enable, ext_select} = 4'hF;
      wait_on(ext_active, 100);
      note(7'h1E, 7'h10, "switch");
      ext_run = 0;
      wait_on(fail_flag, 400);
      note(7'h1E, 7'h0C, "fail");
      ext_run = 1;
      repeat (40) @(negedge clk);
      note(7'h18, 7'h08, "refuse");
      {ext_select, fail_irq_enable, fail_clear} = 3'h1;
      @(negedge clk);
      fail_clear = 0;
      repeat (4) @(negedge clk);
      note(7'h0C, 7'h00, "clear");
      ext_select = 1;
      wait_on(ext_active, 100);
      ext_run = 0;
      wait_on(fail_flag, 400);
      note(7'h0C, 7'h08, "masked");
      mult_run = 0;
      wait_on(mult_fail_irq, 400);
      note(7'h02, 7'h02, "mult");
      results;
   end
endmodule
`default_nettype wire

// ### verif/scsm_osc_model.sv
// Oscillator and bus clock model at the far side of the clock select block.
// Assumes the bench stops the external and multiplier sources by the run inputs.
`default_nettype none
module scsm_osc_model (
   input  wire logic ext_run,
   input  wire logic mult_run,
   output var  logic int_osc,
   output var  logic ext_osc,
   output var  logic mult_clk,
   output var  logic slow_tick,
   output var  logic fast_tick
);
   timeunit 1ns;
   timeprecision 100ps;
   // All sources start low
   initial {int_osc, ext_osc, mult_clk, slow_tick, fast_tick} = '0;
   // Internal source, 8 MHz
   always #62.5 int_osc = ~int_osc;
   // A stopped source holds its level, so no edge reaches the monitor
   always #62 if (ext_run) ext_osc = ~ext_osc;
   always #10.4 if (mult_run) mult_clk = ~mult_clk;
   // Bus clocks kept well below their ceilings
   always #64 slow_tick = ~slow_tick;
   // Fast bus at 14 MHz, one of the rates that suits the converter
   always #35.7 fast_tick = ~fast_tick;
endmodule
`default_nettype wire
